// ### hdl/fwl_pkg.sv
// ============================================================
// Shared constants and types of the write latch and status block
package fwl_pkg;

    // ============================================================
    // Status byte layout
    localparam int STAT_BUSY_BIT = 0;        // Operation running
    localparam int STAT_LATCH_BIT = 1;       // Write latch
    localparam int STAT_LEVEL_LSB = 2;       // Protect level low bit
    localparam int STAT_LEVEL_MSB = 5;       // Protect level high bit
    localparam int STAT_QUAD_BIT = 6;        // Quad pins enable
    localparam int STAT_LOCK_BIT = 7;        // Status lock
    localparam logic [5:0] STAT_NV_RESET = 6'h00; // Factory value of bits 7..2

    // ============================================================
    // Frame geometry
    localparam logic [2:0] BYTES_OPC = 3'h1;     // Opcode only
    localparam logic [2:0] BYTES_SW = 3'h2;      // Opcode and status byte
    localparam logic [2:0] BYTES_ERASE = 3'h4;   // Opcode and three address bytes
    localparam logic [2:0] BYTES_PROG = 3'h5;    // Address plus at least one data byte
    localparam logic [4:0] ID_BITS = 5'h18;      // Identification length

    // ============================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;           // Reference clock period
    localparam int STATUS_WRITE_TIME_US = 10;    // Self-timed status write
    localparam int SW_CYCLES = (STATUS_WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ============================================================
    // Protection map: blocks shielded from the top per level
    localparam int ADDR_W = 24;                  // Byte address width
    localparam int BLOCK_SHIFT = 16;             // Block size is 64 KB
    localparam logic [15:0][8:0] PROT_TABLE_DEFAULT = {
        9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100,
        9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h000
    };

    // ============================================================
    // Types
    typedef enum logic [2:0] {
        OP_PAGE,
        OP_QUAD_PAGE,
        OP_CONT,
        OP_SECTOR,
        OP_BLOCK,
        OP_CHIP
    } fwl_op_kind_type;

    typedef struct packed {
        logic valid;                  // One-cycle start pulse
        fwl_op_kind_type kind;        // Operation to run
        logic [ADDR_W-1:0] addr;      // Target address
    } fwl_op_req_type;

    typedef struct packed {
        logic cs_n;                   // Synchronised chip select, low active
        logic cs_fall;                // Frame start pulse
        logic cs_rise;                // Frame end pulse
        logic sclk_rise;              // Serial clock rising edge pulse
        logic sclk_fall;              // Serial clock falling edge pulse
        logic si;                     // Serial input aligned with sclk_rise
        logic wp_n;                   // Synchronised write protect pin
    } fwl_link_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STATUS_WRITE,
        ST_PROG_ERASE
    } fwl_state_type;

endpackage

// ### hdl/fwl_link_sync.sv
`timescale 1ns/1ps
// ============================================================
// Pin synchroniser and serial clock edge finder
module fwl_link_sync import fwl_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    input wire logic write_protect_pin_n_i,
    output fwl_link_type link_o
);

    // First and second stages, then one history stage for edges
    logic [3:0] meta_q;      // First stage: read only by sync_q
    logic [3:0] sync_q;      // Second stage: safe levels
    logic [1:0] hist_q;      // Previous cs_n and sclk
    fwl_link_type link_q;    // Registered outputs

    // Order of bits: cs_n, sclk, si, wp_n
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            // Idle pin levels: deselected, clock low, so no false edge follows reset
            meta_q <= 4'h9;
            sync_q <= 4'h9;
            hist_q <= 2'h2;
        end else begin
            meta_q <= {chip_select_n_i, serial_clk_i, serial_in_i, write_protect_pin_n_i};
            sync_q <= meta_q;
            hist_q <= sync_q[3:2];
        end
    end

    // Edge pulses and aligned levels
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            link_q <= '{cs_n: 1'b1, wp_n: 1'b1, default: 1'b0};
        end else begin
            link_q.cs_n <= sync_q[3];
            link_q.cs_fall <= hist_q[1] & ~sync_q[3];
            link_q.cs_rise <= ~hist_q[1] & sync_q[3];
            link_q.sclk_rise <= ~hist_q[0] & sync_q[2];
            link_q.sclk_fall <= hist_q[0] & ~sync_q[2];
            link_q.si <= sync_q[1];
            link_q.wp_n <= sync_q[0];
        end
    end

    assign link_o = link_q;

endmodule

// ### hdl/fwl_core.sv
`timescale 1ns/1ps
// ============================================================
// Serial flash command front end: write latch, status, protection
// Notes on behaviour
// - Latch set command sets write latch
// - One-byte latch clear command clears latch
// - Latch clears at reset and command completion
// - Identify shifts out three identity bytes
// - Identify ignored while an operation runs
// - Status read always allowed, repeats endlessly
// - Busy flag is status bit 0
// - Latch is bit 1, gates writes
// - Protected target ignored, latch unchanged
// - Bits 5..2 select the protected region
// - Chip erase only when level zero
// - Bit 6 selects quad pins, default 0
// - Bit 7 lock plus pin low, bit 6 clear: hard
// - Hard mode refuses status write
// - Soft mode allows status write with latch
// - Status write needs latch set beforehand
// - Status write never touches bits 1, 0
// - Status write must end on byte boundary
// - Timed status write holds busy, then clears
// - Hard mode ends with pin high or four-line read
// - Hard mode off during four-line read
module fwl_core import fwl_pkg::*; #(
    parameter logic [7:0] OPC_LATCH_SET = 8'h11,     // Opcodes: plain defaults
    parameter logic [7:0] OPC_LATCH_CLEAR = 8'h12,
    parameter logic [7:0] OPC_IDENTIFY = 8'h13,
    parameter logic [7:0] OPC_STATUS_READ = 8'h14,
    parameter logic [7:0] OPC_STATUS_WRITE = 8'h15,
    parameter logic [7:0] OPC_PAGE = 8'h16,
    parameter logic [7:0] OPC_QUAD_PAGE = 8'h17,
    parameter logic [7:0] OPC_CONT = 8'h18,
    parameter logic [7:0] OPC_SECTOR = 8'h19,
    parameter logic [7:0] OPC_BLOCK = 8'h1a,
    parameter logic [7:0] OPC_CHIP = 8'h1b,
    parameter logic [7:0] MAKER_CODE = 8'ha5,        // Arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h3c,         // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h16,         // Arbitrary value
    parameter logic [15:0][8:0] PROT_TABLE = PROT_TABLE_DEFAULT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic chip_select_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    input wire logic write_protect_pin_n_i,
    input wire logic quad_read_mode_i,
    input wire logic op_done_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic quad_pins_enable_o,
    output fwl_op_req_type op_req_o
);

    // ============================================================
    // Protection lookup
    // Address falls inside the top region chosen by the level
    function automatic logic region_hit(input logic [ADDR_W-1:0] addr, input logic [3:0] level);
        logic [8:0] size;
        logic [8:0] block;
        size = PROT_TABLE[level];
        block = {1'b0, addr[ADDR_W-1:BLOCK_SHIFT]};
        return (size != 9'h000) && (block >= 9'h100 - size);
    endfunction

    // ============================================================
    // Link front end
    fwl_link_type link;      // Synchronised pins and edges

    fwl_link_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .chip_select_n_i(chip_select_n_i),
        .serial_clk_i(serial_clk_i),
        .serial_in_i(serial_in_i),
        .write_protect_pin_n_i(write_protect_pin_n_i),
        .link_o(link)
    );

    // ============================================================
    // State
    logic [2:0] bit_q;               // Bit within byte
    logic [2:0] byte_q;              // Whole bytes in frame, saturating
    logic [6:0] rx_q;                // Partial byte
    logic [7:0] opc_q;               // Opcode of frame
    logic [7:0] wbyte_q;             // Second byte of frame
    logic [ADDR_W-1:0] addr_q;       // Address bytes
    fwl_state_type state_q;          // Operation engine
    logic [15:0] timer_q;            // Status write countdown
    logic latch_q;                   // Write latch
    logic [5:0] nv_q;                // Status bits 7..2
    logic [5:0] nv_new_q;            // Pending status write value
    logic tx_id_q;                   // Identification shifting
    logic tx_st_q;                   // Status shifting
    logic [4:0] tx_cnt_q;            // Bits sent
    logic [23:0] tx_q;               // Output shifter
    logic so_q;                      // Serial output
    logic oe_q;                      // Serial output enable
    fwl_op_req_type req_q;           // Operation start

    // ============================================================
    // Decoding
    wire framed = ~link.cs_n;
    wire byte_done = link.sclk_rise & framed & (bit_q == 3'h7);
    wire [7:0] rx_byte = {rx_q, link.si};
    wire busy = (state_q != ST_IDLE);
    wire aligned = (bit_q == 3'h0);
    wire len_opc = aligned & (byte_q == BYTES_OPC);
    wire len_sw = aligned & (byte_q == BYTES_SW);
    wire len_erase = aligned & (byte_q == BYTES_ERASE);
    wire len_prog = aligned & (byte_q == BYTES_PROG);
    wire cmd_end = link.cs_rise & ~busy;                  // Frame-end commands, status write included, need idle
    wire is_set = (opc_q == OPC_LATCH_SET);
    wire is_clr = (opc_q == OPC_LATCH_CLEAR);
    wire is_sw = (opc_q == OPC_STATUS_WRITE);
    wire is_chip = (opc_q == OPC_CHIP);
    wire is_erase = (opc_q == OPC_SECTOR) | (opc_q == OPC_BLOCK);
    wire is_prog = (opc_q == OPC_PAGE) | (opc_q == OPC_QUAD_PAGE) | (opc_q == OPC_CONT);
    wire [3:0] level = nv_q[STAT_LEVEL_MSB-2:STAT_LEVEL_LSB-2];
    wire lock = nv_q[STAT_LOCK_BIT-2];
    wire quad_en = nv_q[STAT_QUAD_BIT-2];
    // Pin low with lock; pin ignored when it serves as a quad line
    wire hard_mode = lock & ~link.wp_n & ~quad_en & ~quad_read_mode_i;
    wire set_done = cmd_end & len_opc & is_set;
    wire clr_done = cmd_end & len_opc & is_clr;
    wire sw_frame = cmd_end & len_sw & is_sw;
    wire sw_go = sw_frame & latch_q & ~hard_mode;
    wire pe_frame = cmd_end & ((len_opc & is_chip) | (len_erase & is_erase) | (len_prog & is_prog));
    wire pe_prot = is_chip ? (level != 4'h0) : region_hit(addr_q, level);
    wire pe_go = pe_frame & latch_q & ~pe_prot;
    wire sw_done = (state_q == ST_STATUS_WRITE) & (timer_q == 16'h0000);
    wire pe_done = (state_q == ST_PROG_ERASE) & op_done_i;
    wire [7:0] status_live = {nv_q, latch_q, busy};
    wire tx_on = tx_id_q | tx_st_q;
    wire [23:0] tx_word = (tx_st_q && tx_cnt_q[2:0] == 3'h0) ? {status_live, 16'h0000} : tx_q;
    wire id_stop = tx_id_q & (tx_cnt_q == ID_BITS);

    fwl_op_kind_type pe_kind;        // Kind of a starting operation
    always_comb begin
        unique case (opc_q)
            OPC_QUAD_PAGE: pe_kind = OP_QUAD_PAGE;
            OPC_CONT: pe_kind = OP_CONT;
            OPC_SECTOR: pe_kind = OP_SECTOR;
            OPC_BLOCK: pe_kind = OP_BLOCK;
            OPC_CHIP: pe_kind = OP_CHIP;
            default: pe_kind = OP_PAGE;
        endcase
    end

    // ============================================================
    // Receive shifter and frame counters
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || link.cs_fall) begin
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            rx_q <= 7'h00;
        end else if (link.sclk_rise && framed) begin
            bit_q <= bit_q + 3'h1;
            rx_q <= rx_byte[6:0];
            if (byte_done && byte_q != BYTES_PROG) begin
                byte_q <= byte_q + 3'h1;
            end
        end
    end

    // Opcode, status byte and address capture
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            opc_q <= 8'h00;
            wbyte_q <= 8'h00;
            addr_q <= '0;
        end else if (byte_done) begin
            if (byte_q == 3'h0) begin
                opc_q <= rx_byte;
            end
            if (byte_q == 3'h1) begin
                wbyte_q <= rx_byte;
            end
            if (byte_q != 3'h0 && byte_q < BYTES_ERASE) begin
                addr_q <= {addr_q[ADDR_W-9:0], rx_byte};
            end
        end
    end

    // ============================================================
    // Operation engine
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            timer_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (sw_go) begin
                        state_q <= ST_STATUS_WRITE;
                        timer_q <= 16'(SW_CYCLES - 1);
                    end else if (pe_go) begin
                        state_q <= ST_PROG_ERASE;
                    end
                end
                ST_STATUS_WRITE: begin
                    if (sw_done) begin
                        state_q <= ST_IDLE;
                    end else begin
                        timer_q <= timer_q - 16'h0001;
                    end
                end
                ST_PROG_ERASE: begin
                    if (pe_done) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Write latch: set by its command, cleared on every completion
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            latch_q <= 1'b0;
        end else if (set_done) begin
            latch_q <= 1'b1;
        end else if (clr_done || sw_done || pe_done) begin
            latch_q <= 1'b0;
        end
    end

    // Stored status bits; only bits 7..2 take the written byte
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nv_q <= STAT_NV_RESET;
            nv_new_q <= STAT_NV_RESET;
        end else begin
            if (sw_go) begin
                nv_new_q <= wbyte_q[7:2];
            end
            if (sw_done) begin
                nv_q <= nv_new_q;
            end
        end
    end

    // Start request towards the array engine
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            req_q <= '{kind: OP_PAGE, default: '0};
        end else begin
            req_q.valid <= pe_go;
            if (pe_go) begin
                req_q.kind <= pe_kind;
                req_q.addr <= addr_q;
            end
        end
    end

    // ============================================================
    // Answer shifter: identification once, status repeatedly
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || link.cs_rise || link.cs_fall) begin
            tx_id_q <= 1'b0;
            tx_st_q <= 1'b0;
            tx_cnt_q <= 5'h00;
            tx_q <= 24'h000000;
            so_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (byte_done && byte_q == 3'h0) begin
            tx_id_q <= (rx_byte == OPC_IDENTIFY) & ~busy;
            tx_st_q <= (rx_byte == OPC_STATUS_READ);
            tx_q <= {MAKER_CODE, TYPE_CODE, PART_CODE};
            tx_cnt_q <= 5'h00;
        end else if (link.sclk_fall && framed && tx_on) begin
            if (id_stop) begin
                tx_id_q <= 1'b0;
                oe_q <= 1'b0;
                so_q <= 1'b0;
            end else begin
                so_q <= tx_word[23];
                tx_q <= {tx_word[22:0], 1'b0};
                tx_cnt_q <= tx_cnt_q + 5'h01;
                oe_q <= 1'b1;
            end
        end
    end

    assign serial_out_o = so_q;
    assign serial_out_oe_o = oe_q;
    assign quad_pins_enable_o = nv_q[STAT_QUAD_BIT-2];   // Registered bit
    assign op_req_o = req_q;

    // ============================================================
    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_latch_set_cmd: assert property (set_done |=> latch_q)
        else $error("latch not set by set command");
    a_latch_clear_cmd: assert property (clr_done |=> !latch_q ##1 !latch_q)
        else $error("latch not cleared by clear command");
    a_sw_busy_hold: assert property (sw_go |=> (status_live[0] && state_q == ST_STATUS_WRITE) [*8])
        else $error("busy not held during status write");
    a_sw_done_clear: assert property (sw_done |=> !busy && !latch_q && nv_q == $past(nv_new_q))
        else $error("status write completion wrong");
    a_sw_no_latch: assert property (sw_frame && !latch_q |=> state_q == ST_IDLE)
        else $error("status write taken without latch");
    a_hard_refuse: assert property (sw_frame && hard_mode |=> $stable(nv_q) && !busy)
        else $error("status write taken in hard mode");
    a_chip_level: assert property (pe_frame && is_chip && level != 4'h0 |=> !op_req_o.valid)
        else $error("chip erase started with level set");
    a_protect_keep: assert property (pe_frame && pe_prot && latch_q |=> latch_q && !op_req_o.valid)
        else $error("protected target not ignored");
    a_id_busy_off: assert property (byte_done && byte_q == 3'h0 && busy |=> !tx_id_q)
        else $error("identify decoded while busy");
    a_status_bits: assert property (sw_done |=> status_live[1:0] == 2'b00)
        else $error("written byte reached bits 1 and 0");

endmodule

// ### tb/fwl_host.sv
`timescale 1ns/1ps
// ============================================================
// Host controller model: SPI mode 0 frames, MSB first
module fwl_host (
    input wire logic ref_clk_i,
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic si_o
);
    logic oe_seen; // Output enable seen during the last frame
    // Idle: deselected, clock low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
        oe_seen = 1'b0;
    end
    // Half a serial clock period, launched just after a reference edge
    task automatic half();
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask
    // One frame of nbits; tx left aligned, rx collects bits at rising edges
    task automatic frame(input int nbits, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        oe_seen = 1'b0;
        half();
        cs_n_o = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            si_o = tx[63-i];
            half();
            rx = {rx[62:0], so_i};
            oe_seen = oe_seen | so_oe_i;
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        half();
        // Caller picks the length, so one frame per command
        cs_n_o = 1'b1;
        // Released line never keeps its last value
        si_o = ~si_o;
        half();
    endtask
endmodule

// ### tb/flash_write_latch_status_protect_bench.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench of the write latch and status block
module flash_write_latch_status_protect_bench import fwl_pkg::*; ;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, sclk, si, so, so_oe, quad_en;
    logic wp_n = 1'b1;
    logic quad_rd = 1'b0;
    logic op_done = 1'b0;
    fwl_op_req_type req;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int nreq = 0; // Start pulses seen
    logic [2:0] last_kind;
    logic [23:0] last_addr;
    logic [7:0] stat_m = 8'h00; // Model of the status byte
    logic [31:0] lfsr_q = 32'h87e69e0e;
    logic [63:0] rx;
    // ============================================================
    // Design and host
    fwl_core DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .chip_select_n_i(cs_n),
        .serial_clk_i(sclk), .serial_in_i(si), .write_protect_pin_n_i(wp_n),
        .quad_read_mode_i(quad_rd), .op_done_i(op_done), .serial_out_o(so),
        .serial_out_oe_o(so_oe), .quad_pins_enable_o(quad_en), .op_req_o(req));
    fwl_host host (.ref_clk_i(ref_clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
        .sclk_o(sclk), .si_o(si));
    // Clock
    always #5 ref_clk_i = ~ref_clk_i;
    // ============================================================
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic final_report();
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Two status bytes in one frame, both must match the model
    task automatic rd_status(input logic [7:0] exp);
        host.frame(24, {DUT.OPC_STATUS_READ, 56'h0}, rx);
        check(rx[15:8], exp);
        check(rx[7:0], exp);
    endtask
    task automatic set_latch();
        host.frame(8, {DUT.OPC_LATCH_SET, 56'h0}, rx);
        stat_m[1] = 1'b1;
        rd_status(stat_m);
    endtask
    task automatic wr_status(input logic [7:0] v, input bit ok);
        int t0;
        host.frame(16, {DUT.OPC_STATUS_WRITE, v, 48'h0}, rx);
        t0 = cycles;
        if (ok) begin
            rd_status(stat_m | 8'h01);
            host.frame(32, {DUT.OPC_IDENTIFY, 56'h0}, rx);
            check(host.oe_seen, 1'b0);
            // Poll the busy bit until the timed write is over
            do host.frame(16, {DUT.OPC_STATUS_READ, 56'h0}, rx);
            while (rx[0] !== 1'b0);
            check(cycles - t0 >= SW_CYCLES, 1'b1);
            stat_m = {v[7:2], 2'b00};
        end
        rd_status(stat_m);
    endtask
    // Program or erase of kind k; lengths follow the frame geometry
    task automatic run_op(input int k, input logic [23:0] a, input bit ok);
        int n0;
        int nb;
        n0 = nreq;
        nb = (k < 3) ? 40 : (k < 5) ? 32 : 8;
        host.frame(nb, {DUT.OPC_PAGE + 8'(k), a, 32'h0}, rx);
        // Start pulse follows the seen frame end by a cycle; let the monitor count it
        repeat (2) @(posedge ref_clk_i);
        #1;
        if (ok) begin
            check(nreq, n0 + 1);
            check(last_kind, k);
            if (k < 5) check(last_addr, a);
            rd_status(stat_m | 8'h01);
            @(posedge ref_clk_i);
            #1 op_done = 1'b1;
            @(posedge ref_clk_i);
            #1 op_done = 1'b0;
            stat_m[1:0] = 2'b00;
        end else check(nreq, n0);
        rd_status(stat_m);
    endtask
    // ============================================================
    // Start pulse monitor and hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (req.valid === 1'b1) begin
            nreq++;
            last_kind = req.kind;
            last_addr = req.addr;
        end
        if (cycles > 60000) begin
            failures++;
            final_report();
        end
    end
    // ============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk_i);
        #1 rst_i = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        check(quad_en, 1'b0);
        rd_status(8'h00);
        host.frame(32, {DUT.OPC_IDENTIFY, 56'h0}, rx);
        check(rx[23:0], {DUT.MAKER_CODE, DUT.TYPE_CODE, DUT.PART_CODE});
        set_latch();
        host.frame(8, {DUT.OPC_LATCH_CLEAR, 56'h0}, rx);
        stat_m = 8'h00;
        rd_status(stat_m);
        // Every program and erase kind at level zero
        for (int k = 0; k < 6; k++) begin
            set_latch();
            lfsr_q = lfsr_next(lfsr_q);
            run_op(k, lfsr_q[23:0], 1'b1);
        end
        run_op(0, 24'h000100, 1'b0);
        wr_status(8'hfc, 1'b0);
        set_latch();
        lfsr_q = lfsr_next(lfsr_q);
        wr_status(lfsr_q[7:0] | 8'h43, 1'b1);
        check(quad_en, 1'b1);
        set_latch();
        wr_status(8'h84, 1'b1);
        wp_n = 1'b0;
        set_latch();
        wr_status(8'h00, 1'b0);
        quad_rd = 1'b1;
        wr_status(8'h84, 1'b1);
        quad_rd = 1'b0;
        set_latch();
        wp_n = 1'b1;
        wr_status(8'h84, 1'b1);
        set_latch();
        host.frame(15, {DUT.OPC_STATUS_WRITE, 8'h00, 48'h0}, rx);
        rd_status(stat_m);
        run_op(3, 24'hff0000, 1'b0);
        run_op(5, 24'h000000, 1'b0);
        run_op(3, 24'h000000, 1'b1);
        final_report();
    end
endmodule
